// ===== logic/atr_mem.sv
// Purpose: Small store holding the answer-to-reset characters.
// Assumes: One write port, one read port, registered read data.
// Notes: Contents are not cleared by reset.
`timescale 1ns/1ns
module atr_mem #(
  parameter int DEPTH = 33,
  parameter int AW = 6
) (
  input wire logic clock_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [DEPTH];

  // Write port
  always_ff @(posedge clock_i) begin
    if (we_i && (32'(waddr_i) < DEPTH)) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge clock_i) begin
    rdata_o <= (32'(raddr_i) < DEPTH) ? mem[raddr_i] : 8'h00;
  end
endmodule : atr_mem

// ===== logic/card_link.sv
// Purpose: Card-side half-duplex character link with answer to reset.
// Assumes: clock_i is the clock supplied by the terminal; rst_i is its reset.
// Notes: Direct convention, even parity, 12 etu per sent character.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
module card_link #(
  parameter logic [7:0] DOZE_INS = 8'h00,
  parameter int ATR_DEPTH = 33
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic io_i,
  output logic io_o,
  output logic io_oe_o,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic op_state_o,
  output logic stop_safe_o,
  output logic fast_clock_need_o
);
  // ***************************************************************
  // Declarations
  // ***************************************************************
  card_link_pkg::tx_state_t tx_state_q;
  logic cmd_busy_q, pps_ok_q, atr_pend_q, atr_done_q, doze_pend_q, doze_idx_q, doze_seen_q;
  logic [15:0] div_q, div_eff, tx_cnt_q, rx_cnt_q;
  logic [7:0] fchar_q, tx_byte_q, rx_data_q, atr_rdata;
  logic [5:0] atr_len_q, atr_wptr_q, atr_idx_q;
  logic [3:0] tx_bit_q, rx_bit_q;
  logic [9:0] tx_frame_q, rx_sh_q;
  logic [7:0] buf_q [2];
  logic buf_wp_q, buf_rp_q, tx_drop_q, rx_busy_q, rx_wait_q, rx_valid_q, par_err_q, hdr_match_q;
  logic [1:0] buf_cnt_q;
  logic [2:0] hdr_cnt_q;
  logic [10:0] quiet_cnt_q;
  logic wr_atr, push, pop, load, char_done, rx_done, rx_sample, rx_start;
  logic [7:0] load_byte;
  logic [8:0] rx_word;

  // Address decode shared by the write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // Bit time: the reset divisor until PPS succeeds
  assign div_eff = pps_ok_q ? div_q : card_link_pkg::ETU_DEFAULT;
  assign wr_atr = wr_i && hit(addr_i, card_link_pkg::OFS_ATR_DATA);
  assign push = wr_i && hit(addr_i, card_link_pkg::OFS_DATA) && (buf_cnt_q != 2'h2);
  assign load = (tx_state_q == card_link_pkg::TX_FETCH);
  assign pop = load && atr_done_q && !doze_pend_q;
  assign char_done = (tx_state_q == card_link_pkg::TX_SEND) && (tx_cnt_q == div_eff - 16'h0001)
                     && (tx_bit_q == card_link_pkg::TX_LAST_BIT);
  assign rx_start = !rx_busy_q && !rx_wait_q && (tx_state_q == card_link_pkg::TX_IDLE) && !io_i;
  assign rx_sample = rx_busy_q && (rx_cnt_q == 16'h0000);
  assign rx_done = rx_sample && (rx_bit_q == card_link_pkg::RX_LAST_BIT);
  assign rx_word = {io_i, rx_sh_q[9:2]};

  // Character source: answer to reset, then doze status, then the buffer
  always_comb begin
    if (!atr_done_q) begin
      load_byte = atr_rdata;
    end else if (doze_pend_q) begin
      load_byte = doze_idx_q ? card_link_pkg::SW2_NORMAL : card_link_pkg::SW1_NORMAL;
    end else begin
      load_byte = buf_q[buf_rp_q];
    end
  end

  // ***************************************************************
  // Software registers
  // ***************************************************************
  // Control, divisor and file characteristics
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_busy_q <= 1'b0;
      pps_ok_q <= 1'b0;
      div_q <= card_link_pkg::DIV_RST;
      fchar_q <= card_link_pkg::FCHAR_RST;
    end else if (wr_i) begin
      if (hit(addr_i, card_link_pkg::OFS_CTRL)) begin
        cmd_busy_q <= wdata_i[card_link_pkg::CTRL_CMD_BUSY];
        pps_ok_q <= wdata_i[card_link_pkg::CTRL_PPS_OK] && atr_done_q;
      end
      if (hit(addr_i, card_link_pkg::OFS_DIV_LO)) div_q[7:0] <= wdata_i;
      if (hit(addr_i, card_link_pkg::OFS_DIV_HI)) div_q[15:8] <= wdata_i;
      if (hit(addr_i, card_link_pkg::OFS_FCHAR)) fchar_q <= wdata_i;
    end
  end

  // Answer-to-reset length and load pointer, capped at the legal count
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      atr_len_q <= 6'h00;
      atr_wptr_q <= 6'h00;
      atr_pend_q <= 1'b0;
    end else if (wr_i && hit(addr_i, card_link_pkg::OFS_ATR_LEN) && !atr_pend_q) begin
      atr_len_q <= (wdata_i > 8'(card_link_pkg::ATR_MAX)) ? card_link_pkg::ATR_MAX : wdata_i[5:0];
      atr_wptr_q <= 6'h00;
      atr_pend_q <= 1'b1;
    end else if (wr_atr && (atr_wptr_q != card_link_pkg::ATR_MAX)) begin
      atr_wptr_q <= atr_wptr_q + 6'h01;
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        card_link_pkg::OFS_CTRL: rdata_o <= {6'h00, pps_ok_q, cmd_busy_q};
        card_link_pkg::OFS_DIV_LO: rdata_o <= div_q[7:0];
        card_link_pkg::OFS_DIV_HI: rdata_o <= div_q[15:8];
        card_link_pkg::OFS_FCHAR: rdata_o <= fchar_q;
        card_link_pkg::OFS_ATR_LEN: rdata_o <= {2'h0, atr_len_q};
        card_link_pkg::OFS_DATA: rdata_o <= rx_data_q;
        card_link_pkg::OFS_STATUS: rdata_o <= {par_err_q, tx_drop_q, doze_seen_q, stop_safe_o,
                                              atr_done_q, rx_valid_q, buf_cnt_q != 2'h2, op_state_o};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Store for the answer-to-reset characters
  atr_mem #(.DEPTH(ATR_DEPTH), .AW(6)) u_atr_mem (
    .clock_i(clock_i),
    .we_i(wr_atr),
    .waddr_i(atr_wptr_q),
    .wdata_i(wdata_i),
    .raddr_i(atr_idx_q),
    .rdata_o(atr_rdata)
  );

  // ***************************************************************
  // Two-entry transmit buffer
  // ***************************************************************
  // Writes into a full buffer are dropped and flagged
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      buf_q[0] <= 8'h00;
      buf_q[1] <= 8'h00;
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
      buf_cnt_q <= 2'h0;
      tx_drop_q <= 1'b0;
    end else begin
      if (push) begin
        buf_q[buf_wp_q] <= wdata_i;
        buf_wp_q <= !buf_wp_q;
      end
      if (pop) buf_rp_q <= !buf_rp_q;
      buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
      if (wr_i && hit(addr_i, card_link_pkg::OFS_DATA) && (buf_cnt_q == 2'h2)) begin
        tx_drop_q <= 1'b1;
      end else if (rd_i && hit(addr_i, card_link_pkg::OFS_STATUS)) begin
        tx_drop_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Transmitter
  // ***************************************************************
  // Character sequencer; a new character waits for the line to be free
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_q <= card_link_pkg::TX_IDLE;
      atr_idx_q <= 6'h00;
      atr_done_q <= 1'b0;
      doze_idx_q <= 1'b0;
    end else begin
      case (tx_state_q)
        card_link_pkg::TX_IDLE: begin
          if (atr_pend_q && !atr_done_q && (atr_idx_q == atr_len_q)) begin
            atr_done_q <= 1'b1;
          end else if (!rx_busy_q && !rx_wait_q && ((atr_pend_q && !atr_done_q) || (atr_done_q &&
                       (doze_pend_q || (buf_cnt_q != 2'h0))))) begin
            tx_state_q <= card_link_pkg::TX_FETCH;
          end
        end
        card_link_pkg::TX_FETCH: begin
          tx_state_q <= card_link_pkg::TX_SEND;
          if (!atr_done_q) atr_idx_q <= atr_idx_q + 6'h01;
          else if (doze_pend_q) doze_idx_q <= !doze_idx_q;
        end
        card_link_pkg::TX_SEND: begin
          if (char_done) tx_state_q <= card_link_pkg::TX_IDLE;
        end
        default: tx_state_q <= card_link_pkg::TX_IDLE;
      endcase
    end
  end

  // Bit timing: start, 8 data, parity, then 2 etu of guard time
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_frame_q <= 10'h3ff;
      tx_byte_q <= 8'h00;
      io_o <= 1'b1;
      io_oe_o <= 1'b0;
    end else if (load) begin
      tx_frame_q <= {^load_byte, load_byte, 1'b0};
      tx_byte_q <= load_byte;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      io_o <= 1'b0;
      io_oe_o <= 1'b1;
    end else if (tx_state_q == card_link_pkg::TX_SEND) begin
      if (tx_cnt_q == div_eff - 16'h0001) begin
        tx_cnt_q <= 16'h0000;
        tx_bit_q <= tx_bit_q + 4'h1;
        io_o <= (tx_bit_q < 4'h9) ? tx_frame_q[tx_bit_q + 4'h1] : 1'b1;
        io_oe_o <= tx_bit_q < 4'h9;
      end else begin
        tx_cnt_q <= tx_cnt_q + 16'h0001;
      end
    end
  end

  // ***************************************************************
  // Receiver
  // ***************************************************************
  // Samples mid-bit; after parity it waits for the line to go high
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_busy_q <= 1'b0;
      rx_wait_q <= 1'b0;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 10'h000;
    end else if (rx_start) begin
      rx_busy_q <= 1'b1;
      rx_cnt_q <= {1'b0, div_eff[15:1]};
      rx_bit_q <= 4'h0;
    end else if (rx_sample) begin
      rx_sh_q <= {io_i, rx_sh_q[9:1]};
      rx_cnt_q <= div_eff - 16'h0001;
      rx_bit_q <= rx_bit_q + 4'h1;
      if (rx_done) begin
        rx_busy_q <= 1'b0;
        rx_wait_q <= 1'b1;
      end
    end else if (rx_busy_q) begin
      rx_cnt_q <= rx_cnt_q - 16'h0001;
    end else if (rx_wait_q && io_i) begin
      rx_wait_q <= 1'b0;
    end
  end

  // Received byte and flags; a new byte wins over a clearing read
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      par_err_q <= 1'b0;
    end else if (rx_done) begin
      rx_data_q <= rx_word[7:0];
      rx_valid_q <= 1'b1;
      par_err_q <= ^rx_word;
    end else if (rd_i && hit(addr_i, card_link_pkg::OFS_DATA)) begin
      rx_valid_q <= 1'b0;
      par_err_q <= 1'b0;
    end
  end

  // Header watch for the legacy doze command; status is queued on match
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hdr_cnt_q <= 3'h0;
      hdr_match_q <= 1'b0;
      doze_pend_q <= 1'b0;
      doze_seen_q <= 1'b0;
    end else begin
      if (rx_done && !cmd_busy_q && !(^rx_word) && atr_done_q) begin
        hdr_cnt_q <= (hdr_cnt_q == 3'h4) ? 3'h0 : hdr_cnt_q + 3'h1;
        if (hdr_cnt_q == 3'h1) hdr_match_q <= rx_word[7:0] == DOZE_INS;
        if ((hdr_cnt_q == 3'h4) && hdr_match_q) begin
          doze_pend_q <= 1'b1;
          doze_seen_q <= 1'b1;
        end
      end else if (char_done) begin
        hdr_cnt_q <= 3'h0;
      end
      if (load && atr_done_q && doze_pend_q && doze_idx_q) doze_pend_q <= 1'b0;
    end
  end

  // ***************************************************************
  // Power state and quiet time
  // ***************************************************************
  // Operating while anything is in progress, idle otherwise
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      op_state_o <= 1'b0;
      fast_clock_need_o <= 1'b0;
    end else begin
      op_state_o <= cmd_busy_q || (tx_state_q != card_link_pkg::TX_IDLE) || rx_busy_q || doze_pend_q
                    || (atr_pend_q && !atr_done_q);
      fast_clock_need_o <= fchar_q[card_link_pkg::FCHAR_FAST_CLK];
    end
  end

  // Card clock cycles since the line last carried a character
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_cnt_q <= 11'h000;
      stop_safe_o <= 1'b0;
    end else if ((tx_state_q != card_link_pkg::TX_IDLE) || rx_busy_q || rx_start) begin
      quiet_cnt_q <= 11'h000;
      stop_safe_o <= 1'b0;
    end else if (quiet_cnt_q != card_link_pkg::STOP_WAIT) begin
      quiet_cnt_q <= quiet_cnt_q + 11'h001;
    end else begin
      stop_safe_o <= 1'b1;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_etu_bound;
    @(posedge clock_i) disable iff (rst_i) (tx_cnt_q < div_eff) && (!rx_busy_q || rx_cnt_q < div_eff);
  endproperty
  a_etu_bound: assert property (p_etu_bound) else $error("Bit counter beyond bit time");
  property p_fast_flag;
    @(posedge clock_i) disable iff (rst_i)
      wr_i && hit(addr_i, card_link_pkg::OFS_FCHAR) && wdata_i[1] |=> ##1 fast_clock_need_o;
  endproperty
  a_fast_flag: assert property (p_fast_flag) else $error("Fast clock flag not shown");
  property p_op_state;
    @(posedge clock_i) disable iff (rst_i) (tx_state_q == card_link_pkg::TX_SEND) |=> op_state_o;
  endproperty
  a_op_state: assert property (p_op_state) else $error("Idle shown while sending");
  property p_doze_sw1;
    @(posedge clock_i) disable iff (rst_i)
      load && atr_done_q && doze_pend_q && !doze_idx_q |=> tx_byte_q == card_link_pkg::SW1_NORMAL;
  endproperty
  a_doze_sw1: assert property (p_doze_sw1) else $error("Doze answer not normal completion");
  property p_atr_rate;
    @(posedge clock_i) disable iff (rst_i) !atr_done_q |-> div_eff == card_link_pkg::ETU_DEFAULT;
  endproperty
  a_atr_rate: assert property (p_atr_rate) else $error("Answer to reset not at default rate");
  property p_keep_rate;
    @(posedge clock_i) disable iff (rst_i) !pps_ok_q |-> div_eff == card_link_pkg::ETU_DEFAULT;
  endproperty
  a_keep_rate: assert property (p_keep_rate) else $error("Rate changed without PPS");
  property p_atr_len;
    @(posedge clock_i) disable iff (rst_i) (atr_len_q <= card_link_pkg::ATR_MAX) && (atr_idx_q <= atr_len_q);
  endproperty
  a_atr_len: assert property (p_atr_len) else $error("Answer to reset too long");
  property p_quiet;
    @(posedge clock_i) disable iff (rst_i) $rose(stop_safe_o) |-> $past(quiet_cnt_q) == card_link_pkg::STOP_WAIT;
  endproperty
  a_quiet: assert property (p_quiet) else $error("Stop-safe raised early");
  c_atr_end: cover property (@(posedge clock_i) disable iff (rst_i) $rose(atr_done_q));
  c_doze: cover property (@(posedge clock_i) disable iff (rst_i) $rose(doze_pend_q));
  c_buf_full: cover property (@(posedge clock_i) disable iff (rst_i) buf_cnt_q == 2'h2);
  c_rx_byte: cover property (@(posedge clock_i) disable iff (rst_i) rx_done);
endmodule : card_link

// ===== logic/card_link_pkg.sv
// Purpose: Shared constants for the card-side contact link.
// Assumes: Byte-wide register port; offsets are byte addresses.
// Notes: All waits are counted in card clock cycles.
package card_link_pkg;
  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV_LO = 8'h04;
  localparam logic [7:0] OFS_DIV_HI = 8'h08;
  localparam logic [7:0] OFS_FCHAR = 8'h0c;
  localparam logic [7:0] OFS_ATR_LEN = 8'h10;
  localparam logic [7:0] OFS_ATR_DATA = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // Field positions
  localparam int CTRL_CMD_BUSY = 0;
  localparam int CTRL_PPS_OK = 1;
  localparam int FCHAR_FAST_CLK = 1;
  localparam int ST_OPERATING = 0;
  localparam int ST_TX_READY = 1;
  localparam int ST_RX_VALID = 2;
  localparam int ST_ATR_DONE = 3;
  localparam int ST_STOP_SAFE = 4;
  localparam int ST_DOZE_SEEN = 5;
  localparam int ST_TX_DROP = 6;
  localparam int ST_PAR_ERR = 7;
  // Reset values
  localparam logic [7:0] FCHAR_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0174;
  // ***************************************************************
  // Timing and framing counts, in card clock cycles, bits or characters, and status words
  // ***************************************************************
  localparam logic [15:0] ETU_DEFAULT = 16'h0174;
  localparam logic [10:0] STOP_WAIT = 11'h744;
  localparam logic [5:0] ATR_MAX = 6'h21;
  localparam logic [3:0] TX_LAST_BIT = 4'hb;
  localparam logic [3:0] RX_LAST_BIT = 4'h9;
  localparam logic [7:0] SW1_NORMAL = 8'h90;
  localparam logic [7:0] SW2_NORMAL = 8'h00;
  // Transmitter states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FETCH = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;
endpackage : card_link_pkg

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the card-side contact link.
// Assumes: Terminal model on the wire; card clock of 25 MHz.
// Notes: Random bytes come from an LFSR with a fixed seed.
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] DOZE = 8'h00;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic io_o;
  logic io_oe_o;
  logic line;
  logic [7:0] rdata_o;
  logic op_state_o;
  logic stop_safe_o;
  logic fast_clock_need_o;
  int bad_count = 0;
  int compares = 0;
  int k;
  logic [31:0] lfsr_q = 32'h07775afd;
  logic [7:0] v;
  logic [7:0] exp_q[$];

  // Card clock, never stopped, even duty cycle, above the lowest allowed rate
  always #20 clock_i = ~clock_i;

  card_link #(.DOZE_INS(DOZE), .ATR_DEPTH(33)) card_link_i (.clock_i(clock_i), .rst_i(rst_i), .io_i(line),
    .io_o(io_o), .io_oe_o(io_oe_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .op_state_o(op_state_o), .stop_safe_o(stop_safe_o), .fast_clock_need_o(fast_clock_need_o));
  term_model term_model_i (.clock_i(clock_i), .card_io_i(io_o), .card_oe_i(io_oe_o), .line_o(line));

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  function automatic logic exp_fast(input logic [7:0] f);
    return f[card_link_pkg::FCHAR_FAST_CLK];
  endfunction : exp_fast

  task automatic rnd(output logic [7:0] b);
    lfsr_q = lfsr_next(lfsr_q);
    b = lfsr_q[7:0];
  endtask : rnd

  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic test_done(input string n);
    $display("test %s done", n);
  endtask : test_done

  // Bus cycles, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic wait_rx(input int n);
    for (int j = 0; j < 8000 * n && term_model_i.rx_q.size() < n; j++) @(posedge clock_i);
    if (term_model_i.rx_q.size() < n) begin
      bad_count++;
      $display("FAIL rx count expected %0d seen %0d", n, term_model_i.rx_q.size());
      final_report();
    end
  endtask : wait_rx

  task automatic wait_safe(output int c);
    for (c = 0; c < 6000 && stop_safe_o !== 1'b1; c++) @(posedge clock_i);
    if (c == 6000) begin
      bad_count++;
      $display("FAIL stop_safe_o expected 1 seen %b", stop_safe_o);
      final_report();
    end
  endtask : wait_safe

  task automatic check_rx();
    chk("card parity error", 8'h00, term_model_i.par_bad != 0);
    while (exp_q.size() > 0) chk("card char", exp_q.pop_front(), term_model_i.rx_q.pop_front());
  endtask : check_rx

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk("io_o", 8'h01, io_o);
    chk("io_oe_o", 8'h00, io_oe_o);
    chk("rdata_o", 8'h00, rdata_o);
    chk("op_state_o", 8'h00, op_state_o);
    chk("stop_safe_o", 8'h00, stop_safe_o);
    chk("fast_clock_need_o", 8'h00, fast_clock_need_o);
    rd(card_link_pkg::OFS_DIV_LO, v);
    chk("div_lo", card_link_pkg::DIV_RST[7:0], v);
    rd(card_link_pkg::OFS_DIV_HI, v);
    chk("div_hi", card_link_pkg::DIV_RST[15:8], v);
    rd(card_link_pkg::OFS_FCHAR, v);
    chk("fchar", card_link_pkg::FCHAR_RST, v);
    rd(8'h20, v);
    chk("unmapped", 8'h00, v);
    test_done("reset");
    // Fast clock flag, corner values then random ones
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      if (i == 0) v = 8'h02;
      if (i == 1) v = 8'hfd;
      wr(card_link_pkg::OFS_FCHAR, v);
      @(posedge clock_i);
      #1;
      chk("fast_clock_need_o", exp_fast(v), fast_clock_need_o);
    end
    test_done("fast_clock");
    // Answer to reset at 372 cycles per bit; rate switch refused before it ends
    wr(card_link_pkg::OFS_DIV_LO, 8'h20);
    wr(card_link_pkg::OFS_DIV_HI, 8'h00);
    wr(card_link_pkg::OFS_CTRL, 8'h02);
    for (int i = 0; i < 3; i++) begin
      rnd(v);
      if (i == 2) v = 8'hff;
      exp_q.push_back(v);
      wr(card_link_pkg::OFS_ATR_DATA, v);
    end
    wr(card_link_pkg::OFS_ATR_LEN, 8'h03);
    for (int j = 0; j < 50 && io_oe_o !== 1'b1; j++) @(posedge clock_i);
    #1;
    chk("io_oe_o", 8'h01, io_oe_o);
    // A start that never comes is already counted; stop the run here
    if (io_oe_o !== 1'b1) final_report();
    chk("op_state_o", 8'h01, op_state_o);
    wait_rx(3);
    check_rx();
    wait_safe(k);
    chk("stop delay in range", 8'h01, k >= 2046 && k <= 2900);
    chk("op_state_o", 8'h00, op_state_o);
    chk("frame cycles 3720", 8'h01, term_model_i.frame_len == 10 * card_link_pkg::ETU_DEFAULT);
    rd(card_link_pkg::OFS_STATUS, v);
    chk("atr_done", 8'h01, v[card_link_pkg::ST_ATR_DONE]);
    chk("stop_safe bit", 8'h01, v[card_link_pkg::ST_STOP_SAFE]);
    test_done("atr");
    // Negotiated rate, then four back-to-back pushes into the two-entry buffer
    // The third push meets a full buffer while the sequencer is still fetching
    wr(card_link_pkg::OFS_CTRL, 8'h02);
    term_model_i.etu = 32;
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      if (i != 2) exp_q.push_back(v);
      addr_i <= card_link_pkg::OFS_DATA;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clock_i);
    end
    wr_i <= 1'b0;
    rd(card_link_pkg::OFS_STATUS, v);
    chk("tx_drop", 8'h01, v[card_link_pkg::ST_TX_DROP]);
    rd(card_link_pkg::OFS_STATUS, v);
    chk("tx_drop cleared", 8'h00, v[card_link_pkg::ST_TX_DROP]);
    wait_rx(3);
    check_rx();
    wait_safe(k);
    chk("frame cycles 320", 8'h01, term_model_i.frame_len == 320);
    test_done("buffer");
    // Legacy doze header answered with normal completion
    for (int i = 0; i < 5; i++) begin
      rnd(v);
      if (i == 1) v = DOZE;
      term_model_i.send_char(v, 1'b0);
    end
    exp_q.push_back(card_link_pkg::SW1_NORMAL);
    exp_q.push_back(card_link_pkg::SW2_NORMAL);
    wait_rx(2);
    check_rx();
    rd(card_link_pkg::OFS_STATUS, k[7:0]);
    chk("doze_seen", 8'h01, k[card_link_pkg::ST_DOZE_SEEN]);
    rd(card_link_pkg::OFS_DATA, k[15:8]);
    chk("rx byte", v, k[15:8]);
    wait_safe(k);
    test_done("doze");
    // Terminal character with parity turned round
    rnd(v);
    term_model_i.send_char(v, 1'b1);
    rd(card_link_pkg::OFS_STATUS, v);
    chk("par_err", 8'h01, v[card_link_pkg::ST_PAR_ERR]);
    rd(card_link_pkg::OFS_DATA, v);
    rd(card_link_pkg::OFS_STATUS, v);
    chk("par_err cleared", 8'h00, v[card_link_pkg::ST_PAR_ERR]);
    test_done("parity");
    final_report();
  end
endmodule : tb_top

// ===== verification/term_model.sv
// Purpose: Terminal-side model of the card contact link.
// Assumes: Wire has a pull-up; a party pulls it only while it drives.
// Notes: Bit time is etu cycles, 372 until the bench changes it.
`timescale 1ns/1ns
module term_model (
  input wire logic clock_i,
  input wire logic card_io_i,
  input wire logic card_oe_i,
  output logic line_o
);
  logic drv_q = 1'b1;
  logic [7:0] rx_q[$];
  int etu = 372;
  int frame_len = 0;
  int oe_len = 0;
  int par_bad = 0;

  // Wire level: released parties leave it to the pull-up
  assign line_o = (card_oe_i ? card_io_i : 1'b1) & drv_q;

  // Length of each stretch in which the card drives the wire
  always @(posedge clock_i) begin
    if (card_oe_i === 1'b1) begin
      oe_len <= oe_len + 1;
    end else if (oe_len != 0) begin
      frame_len <= oe_len;
      oe_len <= 0;
    end
  end

  // ***************************************************************
  // Receiver: samples each card bit in its middle
  // ***************************************************************
  initial begin
    logic [8:0] sh;
    forever begin
      @(posedge clock_i);
      if (card_oe_i === 1'b1 && line_o === 1'b0) begin
        repeat (etu / 2) @(posedge clock_i);
        for (int i = 0; i < 9; i++) begin
          repeat (etu) @(posedge clock_i);
          sh[i] = line_o;
        end
        if (^sh !== 1'b0) par_bad++;
        rx_q.push_back(sh[7:0]);
        while (card_oe_i === 1'b1) @(posedge clock_i);
      end
    end
  end

  // Send one character, parity turned round on request, then guard time
  task automatic send_char(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    f = {(^b) ^ bad, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drv_q <= f[i];
      repeat (etu) @(posedge clock_i);
    end
    drv_q <= 1'b1;
    repeat (2 * etu) @(posedge clock_i);
  endtask : send_char
endmodule : term_model
